// *** adc_sequencer_control.sv ***
// Sequencer, result queues and register file of the converter control block
module adc_sequencer_control #(
  parameter int REF_KHZ = adc_seq_pkg::REF_CLK_KHZ,
  parameter int NUM_EXT_TRIG = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_EXT_TRIG-1:0] ext_trigger,
  output logic conv_start,
  output adc_seq_pkg::conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic [3:0] irq_out
);
  localparam int NS = adc_seq_pkg::NUM_SEQ;
  localparam int RB = adc_seq_pkg::RESULT_BITS;
  // Phase step of the converter tick accumulator
  localparam logic [15:0] TICK_STEP = 16'(adc_seq_pkg::CONV_CLK_KHZ);
  localparam logic [15:0] TICK_WRAP = 16'(REF_KHZ);

  // Tick rate at most the reference, and reference inside the 16-bit phase range
  if (REF_KHZ < adc_seq_pkg::CONV_CLK_KHZ || REF_KHZ > 65535)
  begin : g_bad_ref
    $error("reference clock cannot serve the converter tick");
  end
  if (NUM_EXT_TRIG < 1 || NUM_EXT_TRIG > 14)
  begin : g_bad_trig
    $error("external trigger count out of range");
  end

  // Steps per sequencer, also the queue depth
  function automatic logic [3:0] depth_of(input int s);
    case (s)
      0: depth_of = 4'h8;
      1: depth_of = 4'h4;
      2: depth_of = 4'h4;
      default: depth_of = 4'h1;
    endcase
  endfunction

  logic [3:0] active_reg;
  logic [3:0] raw_irq_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] overrun_reg;
  logic [3:0] underrun_reg;
  logic [15:0] trig_src_reg;
  logic [15:0] priority_reg;
  logic [2:0] average_reg;
  logic loopback_reg;
  logic [31:0] input_sel_reg [NS];
  logic [31:0] step_ctl_reg [NS];
  logic [3:0] pending_reg;
  logic [15:0] phase_reg;
  logic tick;
  logic [31:0] queue_mem [NS][adc_seq_pkg::MAX_STEPS];
  logic [2:0] head_reg [NS];
  logic [2:0] tail_reg [NS];
  logic [3:0] count_reg [NS];
  logic [3:0] push;
  logic [3:0] pop;
  logic [3:0] queue_full;
  logic [3:0] queue_empty;
  logic [3:0] step_irq;
  adc_seq_pkg::seq_state_t state_reg;
  logic [1:0] cur_seq_reg;
  logic [2:0] step_reg;
  logic [6:0] avg_cnt_reg;
  logic [16:0] acc_reg;
  logic [9:0] loop_cnt_reg;
  logic [3:0] start_req;
  logic [1:0] win_seq;
  logic win_any;
  logic [3:0] cur_ctl;
  logic [3:0] cur_sel;
  logic [6:0] avg_total;
  logic [16:0] acc_next;
  logic [9:0] sample;
  logic sample_valid;
  logic last_step;
  logic [31:0] rdata_next;
  logic seq_hit;
  logic [1:0] seq_idx;
  logic [2:0] sub_idx;
  logic wr_en;

  assign wr_en = reg_wr;
  assign seq_hit = reg_addr[11:8] == 4'h0 && reg_addr[7:5] >= 3'h2
    && reg_addr[7:5] <= 3'h5 && reg_addr[1:0] == 2'h0;
  assign seq_idx = 2'(reg_addr[7:5] - 3'h2);
  assign sub_idx = reg_addr[4:2];

  // Fractional divider: average tick rate is CONV over REF per cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      phase_reg <= 16'h0000;
    else if (phase_reg + TICK_STEP >= TICK_WRAP)
      phase_reg <= 16'(phase_reg + TICK_STEP - TICK_WRAP);
    else
      phase_reg <= 16'(phase_reg + TICK_STEP);
  end
  assign tick = (phase_reg + TICK_STEP) >= TICK_WRAP;

  // Plain control registers written by software
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      active_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      trig_src_reg <= 16'h0000;
      priority_reg <= adc_seq_pkg::PRIORITY_RESET[15:0];
      average_reg <= 3'h0;
      loopback_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      case (reg_addr)
        adc_seq_pkg::OFF_ACTIVE: active_reg <= reg_wdata[3:0];
        adc_seq_pkg::OFF_IRQ_MASK: irq_mask_reg <= reg_wdata[3:0];
        adc_seq_pkg::OFF_TRIG_SRC: trig_src_reg <= reg_wdata[15:0];
        adc_seq_pkg::OFF_PRIORITY:
          priority_reg <= reg_wdata[15:0] & 16'h3333;
        adc_seq_pkg::OFF_AVERAGE:
          average_reg <= reg_wdata[2:0] > 3'h6 ? 3'h6 : reg_wdata[2:0];
        adc_seq_pkg::OFF_LOOPBACK: loopback_reg <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // Step nibble registers, width limited to each sequencer's step count
  generate
    for (genvar s = 0; s < NS; s++)
    begin : g_step_cfg
      localparam logic [31:0] NIB_MASK =
        32'((64'h1 << (4 * depth_of(s))) - 64'h1);
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          input_sel_reg[s] <= 32'h0000_0000;
          step_ctl_reg[s] <= (s == NS - 1) ? adc_seq_pkg::STEP_CTL3_RESET
                                           : 32'h0000_0000;
        end
        else if (wr_en && seq_hit && seq_idx == 2'(s))
        begin
          if (sub_idx == adc_seq_pkg::SUB_INPUT_SEL)
            input_sel_reg[s] <= reg_wdata & NIB_MASK;
          if (sub_idx == adc_seq_pkg::SUB_STEP_CTL)
            step_ctl_reg[s] <= reg_wdata & NIB_MASK;
        end
      end
    end
  endgenerate

  // Trigger capture; a pending trigger waits for the arbiter
  generate
    for (genvar s = 0; s < NS; s++)
    begin : g_trigger
      logic [3:0] src;
      logic fire;
      assign src = trig_src_reg[4*s+3:4*s];
      always_comb
      begin
        fire = 1'b0;
        if (src == adc_seq_pkg::TRIG_PROCESSOR)
          fire = wr_en && reg_addr == adc_seq_pkg::OFF_PROC_TRIG
            && reg_wdata[s];
        else if (src == adc_seq_pkg::TRIG_ALWAYS)
          fire = 1'b1;
        else if (int'(src) <= NUM_EXT_TRIG)
          fire = ext_trigger[int'(src) - 1];
      end
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst || !active_reg[s])
          pending_reg[s] <= 1'b0;
        else if (fire)
          pending_reg[s] <= 1'b1;
        else if (start_req[s])
          pending_reg[s] <= 1'b0;
      end
    end
  endgenerate

  // Lowest priority value among pending active sequencers wins
  always_comb
  begin
    logic [2:0] best;
    best = 3'h4;
    win_seq = 2'h0;
    win_any = 1'b0;
    for (int s = 0; s < NS; s++)
    begin
      if (pending_reg[s] && active_reg[s]
          && {1'b0, priority_reg[4*s+1 -: 2]} < best)
      begin
        best = {1'b0, priority_reg[4*s+1 -: 2]};
        win_seq = 2'(s);
        win_any = 1'b1;
      end
    end
  end
  always_comb
  begin
    start_req = 4'h0;
    if (state_reg == adc_seq_pkg::ST_IDLE && win_any && tick)
      start_req[win_seq] = 1'b1;
  end

  // Fields of the step now running
  assign cur_ctl = step_ctl_reg[cur_seq_reg][4*step_reg +: 4];
  assign cur_sel = input_sel_reg[cur_seq_reg][4*step_reg +: 4];
  assign avg_total = 7'(7'h01 << average_reg);
  assign last_step = cur_ctl[adc_seq_pkg::CTL_LAST]
    || {1'b0, step_reg} == depth_of(int'(cur_seq_reg)) - 4'h1;
  // Loopback answers at once with a counting code
  assign sample_valid = loopback_reg ? 1'b1 : conv_done;
  assign sample = loopback_reg ? loop_cnt_reg : conv_data;
  assign acc_next = acc_reg + {7'h00, sample};

  // Step sequencer: start, wait for the sample, average, store
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= adc_seq_pkg::ST_IDLE;
      cur_seq_reg <= 2'h0;
      step_reg <= 3'h0;
      avg_cnt_reg <= 7'h00;
      acc_reg <= 17'h00000;
      conv_start <= 1'b0;
      conv_req <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      case (state_reg)
        adc_seq_pkg::ST_IDLE:
          if (start_req != 4'h0)
          begin
            cur_seq_reg <= win_seq;
            step_reg <= 3'h0;
            avg_cnt_reg <= 7'h00;
            acc_reg <= 17'h00000;
            state_reg <= adc_seq_pkg::ST_START;
          end
        adc_seq_pkg::ST_START:
          if (tick)
          begin
            conv_start <= ~loopback_reg;
            conv_req.temp <= cur_ctl[adc_seq_pkg::CTL_TEMP];
            conv_req.diff <= cur_ctl[adc_seq_pkg::CTL_DIFF];
            if (cur_ctl[adc_seq_pkg::CTL_DIFF])
            begin
              conv_req.pos_input <= {cur_sel[1:0], 1'b0};
              conv_req.neg_input <= {cur_sel[1:0], 1'b1};
            end
            else
            begin
              conv_req.pos_input <= cur_sel[2:0];
              conv_req.neg_input <= 3'h0;
            end
            state_reg <= adc_seq_pkg::ST_WAIT;
          end
        adc_seq_pkg::ST_WAIT:
          if (sample_valid)
          begin
            acc_reg <= acc_next;
            avg_cnt_reg <= 7'(avg_cnt_reg + 7'h01);
            if (7'(avg_cnt_reg + 7'h01) == avg_total)
              state_reg <= adc_seq_pkg::ST_STORE;
            else
              state_reg <= adc_seq_pkg::ST_START;
          end
        adc_seq_pkg::ST_STORE:
        begin
          avg_cnt_reg <= 7'h00;
          acc_reg <= 17'h00000;
          step_reg <= 3'(step_reg + 3'h1);
          state_reg <= last_step ? adc_seq_pkg::ST_IDLE
                                 : adc_seq_pkg::ST_START;
        end
        default: state_reg <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Loopback code advances once per looped sample
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      loop_cnt_reg <= 10'h000;
    else if (loopback_reg && state_reg == adc_seq_pkg::ST_WAIT)
      loop_cnt_reg <= 10'(loop_cnt_reg + 10'h001);
  end

  // Queue traffic; popping is a read of the result address
  always_comb
  begin
    push = 4'h0;
    pop = 4'h0;
    step_irq = 4'h0;
    if (state_reg == adc_seq_pkg::ST_STORE)
    begin
      push[cur_seq_reg] = 1'b1;
      step_irq[cur_seq_reg] = cur_ctl[adc_seq_pkg::CTL_IRQ];
    end
    if (reg_rd && seq_hit && sub_idx == adc_seq_pkg::SUB_RESULT)
      pop[seq_idx] = 1'b1;
  end

  // Circular queues, one per sequencer, depth equal to step count
  generate
    for (genvar s = 0; s < NS; s++)
    begin : g_queue
      localparam logic [3:0] DEPTH = depth_of(s);
      logic do_push;
      logic do_pop;
      assign queue_full[s] = count_reg[s] == DEPTH;
      assign queue_empty[s] = count_reg[s] == 4'h0;
      // Full queue drops the new entry instead of overwriting
      assign do_push = push[s] && !queue_full[s];
      assign do_pop = pop[s] && !queue_empty[s];
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          head_reg[s] <= 3'h0;
          tail_reg[s] <= 3'h0;
          count_reg[s] <= 4'h0;
        end
        else
        begin
          if (do_push)
            tail_reg[s] <= ({1'b0, tail_reg[s]} == DEPTH - 4'h1)
              ? 3'h0 : 3'(tail_reg[s] + 3'h1);
          if (do_pop)
            head_reg[s] <= ({1'b0, head_reg[s]} == DEPTH - 4'h1)
              ? 3'h0 : 3'(head_reg[s] + 3'h1);
          count_reg[s] <= 4'(count_reg[s] + {3'h0, do_push}
            - {3'h0, do_pop});
        end
      end
      always_ff @(posedge ref_clk)
      begin
        if (do_push)
          queue_mem[s][tail_reg[s]] <=
            {22'h000000, 10'(acc_reg[RB - 1 + 6:0] >> average_reg)};
      end
    end
  endgenerate

  // Sticky status; a hardware set wins over a same-cycle clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      raw_irq_reg <= 4'h0;
      overrun_reg <= 4'h0;
      underrun_reg <= 4'h0;
    end
    else
    begin
      raw_irq_reg <= (raw_irq_reg & ~((wr_en
        && reg_addr == adc_seq_pkg::OFF_IRQ_CLEAR)
        ? reg_wdata[3:0] : 4'h0)) | step_irq;
      overrun_reg <= (overrun_reg & ~((wr_en
        && reg_addr == adc_seq_pkg::OFF_OVERRUN)
        ? reg_wdata[3:0] : 4'h0)) | (push & queue_full);
      underrun_reg <= (underrun_reg & ~((wr_en
        && reg_addr == adc_seq_pkg::OFF_UNDERRUN)
        ? reg_wdata[3:0] : 4'h0)) | (pop & queue_empty);
    end
  end

  // Only unmasked interrupts leave the block
  assign irq_out = raw_irq_reg & irq_mask_reg;

  // Read multiplexer; data appear the cycle after the strobe
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (seq_hit)
    begin
      case (sub_idx)
        adc_seq_pkg::SUB_INPUT_SEL: rdata_next = input_sel_reg[seq_idx];
        adc_seq_pkg::SUB_STEP_CTL: rdata_next = step_ctl_reg[seq_idx];
        adc_seq_pkg::SUB_RESULT:
          rdata_next = queue_empty[seq_idx] ? 32'h0000_0000
            : queue_mem[seq_idx][head_reg[seq_idx]];
        adc_seq_pkg::SUB_STATUS:
        begin
          rdata_next[adc_seq_pkg::STAT_TAIL_LSB +: 3] = tail_reg[seq_idx];
          rdata_next[adc_seq_pkg::STAT_HEAD_LSB +: 3] = head_reg[seq_idx];
          rdata_next[adc_seq_pkg::STAT_EMPTY] = queue_empty[seq_idx];
          rdata_next[adc_seq_pkg::STAT_FULL] = queue_full[seq_idx];
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (reg_addr)
        adc_seq_pkg::OFF_ACTIVE: rdata_next[3:0] = active_reg;
        adc_seq_pkg::OFF_RAW_IRQ: rdata_next[3:0] = raw_irq_reg;
        adc_seq_pkg::OFF_IRQ_MASK: rdata_next[3:0] = irq_mask_reg;
        adc_seq_pkg::OFF_IRQ_CLEAR:
          rdata_next[3:0] = raw_irq_reg & irq_mask_reg;
        adc_seq_pkg::OFF_OVERRUN: rdata_next[3:0] = overrun_reg;
        adc_seq_pkg::OFF_TRIG_SRC: rdata_next[15:0] = trig_src_reg;
        adc_seq_pkg::OFF_UNDERRUN: rdata_next[3:0] = underrun_reg;
        adc_seq_pkg::OFF_PRIORITY: rdata_next[15:0] = priority_reg;
        adc_seq_pkg::OFF_AVERAGE: rdata_next[2:0] = average_reg;
        adc_seq_pkg::OFF_LOOPBACK: rdata_next[0] = loopback_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data held only for one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule

// *** adc_seq_pkg.sv ***
// Shared constants and types of the converter sequencer control block
package adc_seq_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_ACTIVE = 12'h000;
  localparam logic [11:0] OFF_RAW_IRQ = 12'h004;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h00C;
  localparam logic [11:0] OFF_OVERRUN = 12'h010;
  localparam logic [11:0] OFF_TRIG_SRC = 12'h014;
  localparam logic [11:0] OFF_UNDERRUN = 12'h018;
  localparam logic [11:0] OFF_PRIORITY = 12'h020;
  localparam logic [11:0] OFF_PROC_TRIG = 12'h028;
  localparam logic [11:0] OFF_AVERAGE = 12'h030;
  localparam logic [11:0] OFF_LOOPBACK = 12'h100;
  // Per-sequencer block: base 0x040, stride 0x020, word index inside
  localparam logic [11:0] OFF_SEQ_BASE = 12'h040;
  localparam int SEQ_STRIDE_LSB = 5;
  localparam logic [2:0] SUB_INPUT_SEL = 3'h0;
  localparam logic [2:0] SUB_STEP_CTL = 3'h1;
  localparam logic [2:0] SUB_RESULT = 3'h2;
  localparam logic [2:0] SUB_STATUS = 3'h3;
  // Reset values
  localparam logic [31:0] PRIORITY_RESET = 32'h0000_3210;
  localparam logic [31:0] STEP_CTL3_RESET = 32'h0000_0002;
  // Step control nibble fields
  localparam int CTL_DIFF = 0;
  localparam int CTL_LAST = 1;
  localparam int CTL_IRQ = 2;
  localparam int CTL_TEMP = 3;
  // Queue status fields
  localparam int STAT_TAIL_LSB = 0;
  localparam int STAT_HEAD_LSB = 4;
  localparam int STAT_EMPTY = 8;
  localparam int STAT_FULL = 12;
  // Trigger source codes
  localparam logic [3:0] TRIG_PROCESSOR = 4'h0;
  localparam logic [3:0] TRIG_ALWAYS = 4'hF;
  // Sequencer geometry
  localparam int NUM_SEQ = 4;
  localparam int MAX_STEPS = 8;
  localparam int RESULT_BITS = 10;
  localparam int AVG_MAX_LOG2 = 6;
  // Converter clock target and reference, in kHz
  localparam int REF_CLK_KHZ = 20000;
  localparam int CONV_CLK_KHZ = 16667;
  localparam int CONV_MIN_KHZ = 14000;
  localparam int CONV_MAX_KHZ = 18000;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE} seq_state_t;

  // Request presented to the analog converter core
  typedef struct packed {
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic diff;
    logic temp;
  } conv_req_t;
endpackage

// *** adc_sequencer_control_chk.sv ***
// Port-level assertions for the converter sequencer control block
module adc_sequencer_control_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic conv_start,
  input wire adc_seq_pkg::conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic [3:0] irq_out
);
  logic [3:0] mask_reg;
  logic [3:0] act_reg;
  logic [15:0] prio_reg;
  logic armed_reg;
  logic busy_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Shadows of software settings; busy spans one converter request
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mask_reg <= 4'h0;
      act_reg <= 4'h0;
      prio_reg <= 16'h3210;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == 12'h008)
        mask_reg <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 12'h000)
        act_reg <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 12'h000 && reg_wdata[3:0] != 4'h0)
        armed_reg <= 1'b1;
      if (reg_wr && reg_addr == 12'h020)
        prio_reg <= reg_wdata[15:0] & 16'h3333;
      if (conv_start)
        busy_reg <= 1'b1;
      else if (conv_done)
        busy_reg <= 1'b0;
    end
  end

  mask_gate_a: assert property ((irq_out & ~mask_reg) == 4'h0)
    else $error("interrupt line high while masked");
  clear_one_a: assert property (reg_wr && reg_addr == 12'h00C
    && reg_wdata[3:0] == 4'hF && act_reg == 4'h0 && !busy_reg
    |=> irq_out == 4'h0) else $error("interrupt not cleared");
  clear_zero_a: assert property (reg_wr && reg_addr == 12'h00C
    && reg_wdata[3:0] == 4'h0 |=> (irq_out & $past(irq_out)) ==
    $past(irq_out)) else $error("zero write dropped an interrupt");
  idle_gate_a: assert property (!armed_reg |-> !conv_start)
    else $error("conversion before any sequencer active");
  one_request_a: assert property (conv_start |-> !busy_reg ##1
    !conv_start) else $error("overlapping converter request");
  req_hold_a: assert property (conv_start |=> $stable(conv_req))
    else $error("request changed during conversion");
  diff_pair_a: assert property (conv_start && conv_req.diff
    |-> !conv_req.pos_input[0] && conv_req.neg_input ==
    conv_req.pos_input + 3'h1) else $error("bad differential pair");
  prio_read_a: assert property (reg_rd && reg_addr == 12'h020
    |=> reg_rdata == {16'h0000, prio_reg})
    else $error("priority readback wrong");
endmodule

bind adc_sequencer_control adc_sequencer_control_chk chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_req(conv_req),
  .conv_done(conv_done), .irq_out(irq_out)
);

// *** adc_conv_model.sv ***
// Behavioural analog converter core facing the sequencer
module adc_conv_model (
  input wire logic ref_clk,
  input wire logic conv_start,
  input wire adc_seq_pkg::conv_req_t conv_req,
  input logic [9:0] level [8],
  input wire logic slow,
  output logic conv_done,
  output logic [9:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  int d = 0;
  logic [9:0] last = 10'h000;
  initial conv_done = 1'b0;
  initial conv_data = 10'h000;

  // One conversion at a time; data lines scramble outside the done pulse
  always @(posedge ref_clk)
  begin
    conv_done <= 1'b0;
    conv_data <= ~last;
    if (conv_start)
    begin
      if (conv_req.diff)
        d = 511 + (int'(level[conv_req.pos_input])
          - int'(level[conv_req.neg_input])) / 2;
      else
        d = int'(level[conv_req.pos_input]);
      wait_cnt <= slow ? 30 : 2;
    end
    else if (wait_cnt == 1)
    begin
      conv_done <= 1'b1;
      conv_data <= 10'(d);
      last <= 10'(d);
      wait_cnt <= 0;
    end
    else if (wait_cnt > 1)
      wait_cnt <= wait_cnt - 1;
  end
endmodule

// *** adc_sequencer_control_tb.sv ***
// Self-checking bench for the converter sequencer control block
module adc_sequencer_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] ext_trigger = 4'h0;
  logic conv_start;
  adc_seq_pkg::conv_req_t conv_req;
  logic conv_done;
  logic [9:0] conv_data;
  logic [3:0] irq_out;
  logic [9:0] level [8];
  logic slow = 1'b0;
  logic [31:0] rv;
  logic [31:0] ins;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0;
  int s0 = 0;
  int k = 0;
  int first_pos = -1;
  int exp_q[$];

  adc_sequencer_control uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trigger(ext_trigger),
    .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .irq_out(irq_out));
  adc_conv_model conv (.ref_clk(ref_clk), .conv_start(conv_start),
    .conv_req(conv_req), .level(level), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));

  // Free-running 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // Watchdog and conversion bookkeeping
  always @(posedge ref_clk)
  begin
    cycles++;
    if (conv_start)
      starts++;
    if (conv_start && first_pos < 0)
      first_pos = conv_req.pos_input;
    if (cycles == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(logic [11:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic wait_raw(int b);
    // Stale data from an earlier read must not end the wait early
    rv = 32'h0;
    for (int i = 0; i < 500 && rv[b] !== 1'b1; i++)
      rd(12'h004);
    chk("raw irq", rv[b], 1'b1);
  endtask

  // Reference code: pair k is inputs 2k minus 2k+1, offset at 511
  function automatic int code(int inp, bit dif);
    if (dif)
      return 511 + (int'(level[2*inp]) - int'(level[2*inp+1])) / 2;
    return int'(level[inp]);
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    rv = $urandom(32'h41A3CED0);
    foreach (level[i])
      level[i] = 10'($urandom);
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(12'h020);
    chk("priority", rv, 32'h0000_3210);
    rd(12'h0A4);
    chk("ctl3", rv, 32'h2);
    rd(12'h030);
    chk("average", rv, 32'h0);
    wr(12'h0F0, 32'hFFFF_FFFF);
    rd(12'h0F0);
    chk("unmapped", rv, 32'h0);
    // Five-step sequence ending early, slow converter
    ins = $urandom & 32'h7777_7777;
    wr(12'h040, ins);
    wr(12'h044, 32'h0006_0000);
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h1);
    slow <= 1'b1;
    for (int i = 0; i < 5; i++)
      exp_q.push_back(code(ins[4*i +: 3], 1'b0));
    wr(12'h028, 32'h1);
    wait_raw(0);
    chk("irq line", irq_out, 32'h1);
    rd(12'h04C);
    chk("status0", rv, 32'h005);
    for (int i = 0; i < 5; i++)
    begin
      rd(12'h048);
      chk("result", rv, exp_q.pop_front());
    end
    rd(12'h048);
    chk("empty pop", rv, 32'h0);
    rd(12'h018);
    chk("underrun", rv, 32'h1);
    wr(12'h00C, 32'h0);
    rd(12'h004);
    chk("raw kept", rv, 32'h1);
    wr(12'h000, 32'h0);
    wr(12'h00C, 32'hF);
    rd(12'h004);
    chk("raw cleared", rv, 32'h0);
    // Differential step on the one-entry sequencer, left masked
    k = $urandom_range(3, 0);
    slow <= 1'b0;
    wr(12'h0A0, k);
    wr(12'h0A4, 32'h7);
    wr(12'h000, 32'h8);
    wr(12'h028, 32'h8);
    wait_raw(3);
    chk("masked line", irq_out, 32'h0);
    rd(12'h00C);
    chk("masked view", rv, 32'h0);
    rd(12'h0A8);
    chk("diff result", rv, code(k, 1'b1));
    // Joint trigger with the highest sequencer given top priority
    wr(12'h020, 32'h0000_0123);
    wr(12'h040, 2 * k + 1);
    wr(12'h000, 32'h9);
    first_pos = -1;
    wr(12'h028, 32'h9);
    wait_raw(0);
    chk("first served", first_pos, 2 * k);
    // Always trigger floods the one-entry queue
    wr(12'h014, 32'h0000_F000);
    wr(12'h000, 32'h8);
    rv = 32'h0;
    for (int i = 0; i < 200 && rv[3] !== 1'b1; i++)
      rd(12'h010);
    chk("overrun", rv[3], 1'b1);
    rd(12'h0AC);
    chk("status3", rv, 32'h0000_1000);
    // Averaging of four samples into one entry
    wr(12'h000, 32'h1);
    wr(12'h00C, 32'h1);
    wr(12'h044, 32'h6);
    wr(12'h040, k);
    wr(12'h030, 32'h2);
    s0 = starts;
    wr(12'h028, 32'h1);
    wait_raw(0);
    chk("averaged starts", starts - s0, 4);
    repeat (5) rd(12'h048);
    rd(12'h048);
    chk("averaged", rv, code(k, 1'b0));
    // Loopback runs without the converter
    wr(12'h100, 32'h1);
    wr(12'h00C, 32'h1);
    s0 = starts;
    wr(12'h028, 32'h1);
    wait_raw(0);
    chk("loopback starts", starts - s0, 0);
    // External trigger code on sequencer one, still looped back
    k = $urandom_range(4, 1);
    wr(12'h014, 32'(k) << 4);
    wr(12'h064, 32'h6);
    wr(12'h000, 32'h2);
    rd(12'h004);
    chk("ext idle", rv[1], 1'b0);
    ext_trigger <= 4'(4'h1 << (k - 1));
    wait_raw(1);
    stop_test();
  end
endmodule
